// ==== rtl/pcs_map.svh ====
/*
 Register offsets, field positions, command codes and reset values of the
 power condition subcommand handler. Definitions only; included by the
 package and by the handler module.
*/
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

// number of power conditions held
`define PCS_COND_NUM 4
`define PCS_TMR_W 24

// register byte addresses
`define PCS_OFF_ARGS 8'h00
`define PCS_OFF_EXEC 8'h04
`define PCS_OFF_CAPS 8'h08
`define PCS_OFF_FEAT 8'h0C
`define PCS_OFF_CUR 8'h10
`define PCS_OFF_SAV 8'h20

// argument register fields
`define PCS_ARG_ID_LSB 0
`define PCS_ARG_PARAM_LSB 8
`define PCS_ARG_TMR_LSB 16

// parameter byte fields
`define PCS_PB_UNITS 7
`define PCS_PB_ENABLE 5
`define PCS_PB_SAVE 4
`define PCS_PB_CODE_MSB 3

// subcommand codes
`define PCS_SUB_TIMER 4'h2
`define PCS_SUB_STATE 4'h3
`define PCS_SUB_ENA 4'h4
`define PCS_SUB_DIS 4'h5

// capability register fields
`define PCS_CAP_CHG_LSB 0
`define PCS_CAP_SAV_LSB 8
`define PCS_CAP_SUPP 16

// timer limits, in 100 ms steps; minute steps scale by 600
`define PCS_TMR_MAX 24'h3BFFC4
`define PCS_TMR_MIN 24'h000000
`define PCS_STEPS_PER_MIN 32'h00000258

// completion state and error flag bits
`define PCS_ST_RDY 6
`define PCS_ST_ERR 0
`define PCS_ERR_ABORT_FLAG 2
`define PCS_ST_RESET 8'h40

`endif

// ==== rtl/pcs_pkg.sv ====
/*
 Types of the power condition subcommand handler.
 Assumes pcs_map.svh is on the include path.
*/
`include "pcs_map.svh"

package pcs_pkg;
	localparam int COND_NUM = `PCS_COND_NUM;
	localparam int TMR_W = `PCS_TMR_W;

	typedef logic [TMR_W-1:0] pcs_tmr_t;

	typedef enum logic [1:0] {
		PCS_IDLE,
		PCS_DONE
	} pcs_phase_t;

	typedef struct packed {
		pcs_phase_t phase;
		logic extended_power_conditions;
		logic [7:0] command_completion_state;
		logic [7:0] command_error_flags;
		logic [7:0] arg_id;
		logic [7:0] arg_param;
		logic [15:0] arg_tmr;
		logic [COND_NUM-1:0] cap_chg;
		logic [COND_NUM-1:0] cap_sav;
		logic cap_supp;
		pcs_tmr_t [COND_NUM-1:0] cur_tmr;
		logic [COND_NUM-1:0] cur_en;
		pcs_tmr_t [COND_NUM-1:0] sav_tmr;
		logic [COND_NUM-1:0] sav_en;
		logic [COND_NUM-1:0] run;
		logic mgmt_off;
		logic done;
		logic [31:0] prdata;
	} pcs_state_t;
endpackage

// ==== rtl/pcs_handler.sv ====
/*
 Power condition subcommand handler: decodes timer, state, feature enable
 and feature disable subcommands written over APB and keeps the current
 and saved timer settings of each power condition.
 Assumes an APB master on mclk_i; dev_reset_i is a same-clock pulse for a
 drive reset (power-on, hardware or software) that must not touch the
 feature flag; nrst_i is the logic power-up reset.
*/
// Notes on behaviour
// - timer units bit: clear means 100 ms steps, set means one-minute steps
// - out-of-range requested timer is clamped to largest or smallest setting
// - largest setting is 3BFFC4h in 100 ms steps, smallest is zero
// - parameter bit 5 requests enable, bit 4 requests saving on completion
// - low nibble code 2h selects the timer-setting subcommand
// - timer setting aborts on unchangeable condition, disabled feature, unsavable save
// - an aborted timer or state subcommand changes no power condition setting
// - code 3h selects state setting; no timer; bits 7 and 6 reserved
// - successful state setting enables current timer from the enable flag
// - successful state setting with save copies current enabled flag to saved
// - state setting aborts on unchangeable condition, disabled feature, unsavable save
// - code 4h turns feature on, sets identify bit, disables automatic management
// - on enable, current timer loads default if saved is zero, else saved
// - on enable, timer starts only when setting non-zero and enabled
// - enabled feature stays enabled through every drive reset
// - feature enable aborts when the feature set is not supported
// - code 5h stops all timers, turns feature off, clears identify bit
// - disabled feature stays disabled through every drive reset
// - feature disable aborts when already disabled or not supported
// - successful timer setting copies timer; enables only if flag set and non-zero
// - timer setting with save on savable condition copies timer and flag to saved
`include "pcs_map.svh"

module pcs_handler #(
	parameter logic [`PCS_TMR_W-1:0] DEF_TMR = 24'h000BB8
) (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic dev_reset_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic extended_power_conditions_o,
	output logic ident_w120_b7_o,
	output logic automatic_power_management_off_o,
	output logic [pcs_pkg::COND_NUM-1:0] timer_run_o,
	output logic cmd_done_o,
	output logic [7:0] command_completion_state_o,
	output logic [7:0] command_error_flags_o
);
	import pcs_pkg::*;

	pcs_state_t st_r;
	pcs_state_t st_nxt;

	logic setup;
	logic wr_acc;
	logic hit;
	logic [31:0] rd_word;
	logic exec;
	logic [3:0] code;
	logic units;
	logic want_en;
	logic want_sav;
	logic id_ok;
	logic [1:0] idx;
	logic abort;
	logic [31:0] req_steps;
	pcs_tmr_t new_tmr;

	assign setup = psel_i && !penable_i;
	assign wr_acc = psel_i && penable_i && pwrite_i;
	assign pready_o = 1'b1;

	// decode of the address; anything else answers with an error
	always_comb begin
		hit = 1'b1;
		rd_word = 32'h00000000;
		case (paddr_i)
			`PCS_OFF_ARGS: rd_word = {st_r.arg_tmr, st_r.arg_param, st_r.arg_id};
			`PCS_OFF_EXEC: rd_word = {16'h0000, st_r.command_error_flags,
				st_r.command_completion_state};
			`PCS_OFF_CAPS: begin
				rd_word[`PCS_CAP_CHG_LSB +: COND_NUM] = st_r.cap_chg;
				rd_word[`PCS_CAP_SAV_LSB +: COND_NUM] = st_r.cap_sav;
				rd_word[`PCS_CAP_SUPP] = st_r.cap_supp;
			end
			`PCS_OFF_FEAT: rd_word = {{(32-COND_NUM-1){1'b0}}, st_r.run,
				st_r.extended_power_conditions};
			default: begin
				hit = 1'b0;
				for (int i = 0; i < COND_NUM; i++) begin
					if (paddr_i == `PCS_OFF_CUR + 8'(4 * i)) begin
						hit = 1'b1;
						rd_word = {7'h00, st_r.cur_en[i], st_r.cur_tmr[i]};
					end
					if (paddr_i == `PCS_OFF_SAV + 8'(4 * i)) begin
						hit = 1'b1;
						rd_word = {7'h00, st_r.sav_en[i], st_r.sav_tmr[i]};
					end
				end
			end
		endcase
	end

	assign pslverr_o = psel_i && penable_i && !hit;
	assign exec = wr_acc && (paddr_i == `PCS_OFF_EXEC);

	// identifier taken from the sector-count byte
	assign id_ok = st_r.arg_id < 8'(COND_NUM);
	assign idx = st_r.arg_id[1:0];
	// subcommand code in the low nibble
	assign code = st_r.arg_param[`PCS_PB_CODE_MSB:0];
	assign want_en = st_r.arg_param[`PCS_PB_ENABLE];
	assign want_sav = st_r.arg_param[`PCS_PB_SAVE];
	assign units = st_r.arg_param[`PCS_PB_UNITS];

	// scale minute steps to 100 ms steps
	assign req_steps = units ? 32'(st_r.arg_tmr) * `PCS_STEPS_PER_MIN : 32'(st_r.arg_tmr);

	always_comb begin
		if (req_steps > 32'(`PCS_TMR_MAX)) begin
			new_tmr = `PCS_TMR_MAX;
		end else if (req_steps < 32'(`PCS_TMR_MIN)) begin
			new_tmr = `PCS_TMR_MIN;
		end else begin
			new_tmr = req_steps[TMR_W-1:0];
		end
	end

	// abort decision per subcommand
	always_comb begin
		case (code)
			`PCS_SUB_TIMER, `PCS_SUB_STATE: begin
				abort = !st_r.cap_supp || !st_r.extended_power_conditions || !id_ok ||
					!st_r.cap_chg[idx] || (want_sav && !st_r.cap_sav[idx]);
			end
			`PCS_SUB_ENA: abort = !st_r.cap_supp;
			// disable refused when off or unsupported
			`PCS_SUB_DIS: abort = !st_r.cap_supp || !st_r.extended_power_conditions;
			default: abort = 1'b1;
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.mgmt_off = 1'b0;
		st_nxt.done = 1'b0;
		if (setup) begin
			st_nxt.prdata = rd_word;
		end
		if (wr_acc && paddr_i == `PCS_OFF_ARGS) begin
			st_nxt.arg_id = pwdata_i[`PCS_ARG_ID_LSB +: 8];
			st_nxt.arg_param = pwdata_i[`PCS_ARG_PARAM_LSB +: 8];
			st_nxt.arg_tmr = pwdata_i[`PCS_ARG_TMR_LSB +: 16];
		end
		if (wr_acc && paddr_i == `PCS_OFF_CAPS) begin
			st_nxt.cap_chg = pwdata_i[`PCS_CAP_CHG_LSB +: COND_NUM];
			st_nxt.cap_sav = pwdata_i[`PCS_CAP_SAV_LSB +: COND_NUM];
			st_nxt.cap_supp = pwdata_i[`PCS_CAP_SUPP];
		end
		// drive reset clears result only
		// a command finishing in the same cycle wins, so its result is not lost
		if (dev_reset_i) begin
			st_nxt.command_completion_state = `PCS_ST_RESET;
			st_nxt.command_error_flags = 8'h00;
		end
		case (st_r.phase)
			PCS_IDLE: begin
				if (exec) begin
					st_nxt.phase = PCS_DONE;
					st_nxt.done = 1'b1;
					st_nxt.command_completion_state = `PCS_ST_RESET;
					st_nxt.command_error_flags = 8'h00;
					if (abort) begin
						// error in status, only abort flag among errors
						st_nxt.command_completion_state[`PCS_ST_ERR] = 1'b1;
						st_nxt.command_error_flags[`PCS_ERR_ABORT_FLAG] = 1'b1;
					end else begin
						case (code)
							`PCS_SUB_TIMER: begin
								// copy timer, enable only when non-zero
								st_nxt.cur_tmr[idx] = new_tmr;
								st_nxt.cur_en[idx] = want_en && (new_tmr != '0);
								if (want_sav) begin
									st_nxt.sav_tmr[idx] = new_tmr;
									st_nxt.sav_en[idx] = want_en && (new_tmr != '0);
								end
							end
							`PCS_SUB_STATE: begin
								st_nxt.cur_en[idx] = want_en;
								if (want_sav) begin
									st_nxt.sav_en[idx] = want_en;
								end
							end
							`PCS_SUB_ENA: begin
								st_nxt.extended_power_conditions = 1'b1;
								st_nxt.mgmt_off = 1'b1;
								for (int i = 0; i < COND_NUM; i++) begin
									st_nxt.cur_tmr[i] = (st_r.sav_tmr[i] == '0) ?
										DEF_TMR : st_r.sav_tmr[i];
									st_nxt.run[i] = (st_nxt.cur_tmr[i] != '0) &&
										st_r.cur_en[i];
								end
							end
							`PCS_SUB_DIS: begin
								// stop all timers and turn feature off
								st_nxt.extended_power_conditions = 1'b0;
								st_nxt.run = '0;
							end
							default: begin
								st_nxt.done = 1'b1;
							end
						endcase
					end
				end
			end
			PCS_DONE: begin
				st_nxt.phase = PCS_IDLE;
			end
			default: begin
				st_nxt.phase = PCS_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= '0;
			st_r.phase <= PCS_IDLE;
			st_r.command_completion_state <= `PCS_ST_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata_o = st_r.prdata;
	assign extended_power_conditions_o = st_r.extended_power_conditions;
	// identify word 120 bit 7 mirrors the feature flag
	assign ident_w120_b7_o = st_r.extended_power_conditions;
	assign automatic_power_management_off_o = st_r.mgmt_off;
	assign timer_run_o = st_r.run;
	assign cmd_done_o = st_r.done;
	assign command_completion_state_o = st_r.command_completion_state;
	assign command_error_flags_o = st_r.command_error_flags;
endmodule

// ==== dv/pcs_handler_asserts.sv ====
/* checker on the handler ports.
 assumes one clock; bound into every pcs_handler */
module pcs_handler_chk (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic pready_o,
	input wire logic extended_power_conditions_o,
	input wire logic ident_w120_b7_o,
	input wire logic automatic_power_management_off_o,
	input wire logic [pcs_pkg::COND_NUM-1:0] timer_run_o,
	input wire logic cmd_done_o,
	input wire logic [7:0] command_completion_state_o,
	input wire logic [7:0] command_error_flags_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import pcs_pkg::*;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	sequence exec_wr;
		psel_i && penable_i && pwrite_i && paddr_i == 8'h04;
	endsequence
	sequence aborted;
		cmd_done_o && command_completion_state_o[0];
	endsequence
	chk_exec_done: assert property (exec_wr |=> cmd_done_o ##1 !cmd_done_o)
		else $error("done pulse wrong after command write");
	chk_abort_code: assert property (aborted |-> command_error_flags_o == 8'h04)
		else $error("abort error flags wrong");
	chk_ok_code: assert property (cmd_done_o && !command_completion_state_o[0]
		|-> command_completion_state_o == 8'h40 && command_error_flags_o == 8'h00)
		else $error("success status wrong");
	chk_abort_keep: assert property (aborted |-> $stable(extended_power_conditions_o)
		&& $stable(timer_run_o) && !automatic_power_management_off_o)
		else $error("abort changed settings");
	chk_ident_copy: assert property (ident_w120_b7_o == extended_power_conditions_o)
		else $error("identify bit differs from feature flag");
	chk_mgmt_pulse: assert property (automatic_power_management_off_o |-> cmd_done_o
		&& extended_power_conditions_o ##1 !automatic_power_management_off_o)
		else $error("management off pulse wrong");
	chk_feat_hold: assert property (!cmd_done_o |-> $stable(extended_power_conditions_o))
		else $error("feature flag moved without command");
	chk_run_off: assert property (!extended_power_conditions_o |-> timer_run_o == '0)
		else $error("timer runs while feature off");
	chk_zero_wait: assert property (psel_i && penable_i |-> pready_o)
		else $error("wait state inserted");
endmodule

bind pcs_handler pcs_handler_chk u_chk (.mclk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i,
	.paddr_i, .pready_o, .extended_power_conditions_o, .ident_w120_b7_o,
	.automatic_power_management_off_o, .timer_run_o, .cmd_done_o,
	.command_completion_state_o, .command_error_flags_o);

// ==== dv/pcs_host.sv ====
/* host controller model: APB master issuing subcommands.
 assumes the same clock as the handler */
module pcs_host (
	input wire logic mclk_i,
	input wire logic [31:0] prdata_i,
	input wire logic pready_i,
	input wire logic pslverr_i,
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [7:0] paddr_o,
	output logic [31:0] pwdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 8'h00;
		pwdata_o = 32'h0;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge mclk_i);
		psel_o <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge mclk_i);
		penable_o <= 1'b1;
		do @(posedge mclk_i); while (pready_i !== 1'b1);
		q = prdata_i;
		e = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		// released lines show garbage, not the old value
		paddr_o <= ~a;
		pwdata_o <= ~d;
	endtask
	task automatic cmd(input logic [7:0] id, input logic [7:0] pb, input logic [15:0] tmr);
		logic [31:0] q;
		logic e;
		xfer(1'b1, 8'h00, {tmr, pb, id}, q, e);
		xfer(1'b1, 8'h04, 32'h0, q, e);
	endtask
endmodule

// ==== dv/tb_top.sv ====
/* self-checking bench of the handler.
 assumes pcs_host and the bound checker are compiled alongside */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pcs_pkg::*;
	localparam logic [23:0] DEF = 24'h000123;
	logic mclk_i = 1'b0;
	logic nrst_i;
	logic dev_reset_i;
	logic psel, penable, pwrite, pready, pslverr, done;
	logic [7:0] paddr, st, er;
	logic [31:0] pwdata, prdata;
	logic [15:0] exp_q[$];
	int mismatches = 0;
	int n_compared = 0;
	initial forever #5 mclk_i = ~mclk_i;
	pcs_handler #(.DEF_TMR(DEF)) u_dut (.mclk_i, .nrst_i, .dev_reset_i, .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.extended_power_conditions_o(), .ident_w120_b7_o(),
		.automatic_power_management_off_o(), .timer_run_o(), .cmd_done_o(done),
		.command_completion_state_o(st), .command_error_flags_o(er));
	pcs_host u_host (.mclk_i, .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr),
		.psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
		.pwdata_o(pwdata));
	task automatic ck(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic xc(input logic [7:0] id, input logic [7:0] pb, input logic [15:0] t,
		input logic ok);
		exp_q.push_back(ok ? 16'h4000 : 16'h4104);
		u_host.cmd(id, pb, t);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		u_host.xfer(1'b0, a, 32'h0, q, e);
		ck("read data", q, exp);
		ck("slave error", {31'h0, e}, {31'h0, a == 8'hFC});
	endtask
	task automatic pulse;
		@(posedge mclk_i);
		dev_reset_i <= 1'b1;
		@(posedge mclk_i);
		dev_reset_i <= 1'b0;
	endtask
	always @(posedge mclk_i) begin
		if (done === 1'b1) begin
			if (exp_q.size() == 0) ck("unexpected done", 32'h1, 32'h0);
			else ck("status errors", {16'h0, st, er}, {16'h0, exp_q.pop_front()});
		end
	end
	initial begin
		repeat (5000) @(posedge mclk_i);
		mismatches++;
		complete_run();
	end
	initial begin
		logic [31:0] r;
		logic e;
		logic [15:0] t;
		nrst_i = 1'b0;
		dev_reset_i = 1'b0;
		void'($urandom(29));
		repeat (8) @(posedge mclk_i);
		nrst_i <= 1'b1;
		rc(8'h08, 32'h0);
		rc(8'hFC, 32'h0);
		xc(8'h00, 8'h04, 16'h0, 1'b0);
		xc(8'h00, 8'h05, 16'h0, 1'b0);
		u_host.xfer(1'b1, 8'h08, 32'h0001_0307, r, e);
		xc(8'h00, 8'h32, 16'h0010, 1'b0);
		xc(8'h00, 8'h04, 16'h0, 1'b1);
		rc(8'h0C, 32'h1);
		rc(8'h10, {8'h0, DEF});
		r = $urandom;
		t = r[15:0];
		xc(8'h00, 8'h32, t, 1'b1);
		rc(8'h10, {7'h0, t != 16'h0, 8'h0, t});
		rc(8'h20, {7'h0, t != 16'h0, 8'h0, t});
		xc(8'h01, 8'hA2, 16'hFFFF, 1'b1);
		rc(8'h14, 32'h013BFFC4);
		xc(8'h01, 8'hA2, 16'h0002, 1'b1);
		rc(8'h14, 32'h010004B0);
		xc(8'h03, 8'h22, 16'h0005, 1'b0);
		rc(8'h1C, {8'h0, DEF});
		xc(8'h02, 8'h12, 16'h0005, 1'b0);
		xc(8'h02, 8'h13, 16'h0, 1'b0);
		rc(8'h18, {8'h0, DEF});
		rc(8'h28, 32'h0);
		xc(8'h07, 8'h03, 16'h0, 1'b0);
		xc(8'h00, 8'h13, 16'h0, 1'b1);
		rc(8'h20, {16'h0, t});
		xc(8'h01, 8'h03, 16'h0, 1'b1);
		rc(8'h14, 32'h000004B0);
		xc(8'h01, 8'h23, 16'h0, 1'b1);
		rc(8'h14, 32'h010004B0);
		xc(8'h00, 8'h07, 16'h0, 1'b0);
		pulse();
		rc(8'h04, 32'h40);
		rc(8'h0C, 32'h1);
		xc(8'h00, 8'h05, 16'h0, 1'b1);
		pulse();
		rc(8'h0C, 32'h0);
		xc(8'h00, 8'h05, 16'h0, 1'b0);
		xc(8'h00, 8'h04, 16'h0, 1'b1);
		rc(8'h0C, 32'h5);
		rc(8'h10, {8'h0, t == 16'h0 ? DEF : {8'h0, t}});
		rc(8'h14, {8'h01, DEF});
		repeat (2) @(posedge mclk_i);
		ck("pending results", 32'(exp_q.size()), 32'h0);
		complete_run();
	end
endmodule
